// *** rail_trim_controller.sv ***
`timescale 1ns/1ns
module rail_trim_controller (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // AXI4-Lite write
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Rail monitor, millivolts per rail, rail 0 in the low bits
    input wire logic [rt_pkg::RAILS*rt_pkg::MV_W-1:0] rail_mv,
    input wire logic all_up,
    // Trim outputs
    output logic [rt_pkg::RAILS-1:0] pwm_out,
    output logic trim_active
);
    reg_if rif();

    logic [1:0] type_q [rt_pkg::RAILS];
    logic [rt_pkg::RAILS-1:0] dac_pwm_q;
    logic [7:0] delay_q [rt_pkg::RAILS];
    logic [11:0] set_q [rt_pkg::RAILS][rt_pkg::NSET];
    logic [11:0] level_q [rt_pkg::RAILS];
    logic [rt_pkg::RAILS-1:0] rail_on;
    rt_pkg::eng_state_t state_q;
    logic [4:0] scan_q;

    logic reload;
    logic wr_rail;
    logic [4:0] wr_idx;
    logic [2:0] wr_fld;
    logic [31:0] wr_word;
    logic [11:0] meas;
    logic [11:0] tgt;
    logic [11:0] cur_lvl;
    logic trim_go;

    function automatic logic rail_hit(input logic [11:0] a);
        logic [11:0] off;
        off = a - rt_pkg::A_RAIL;
        rail_hit = (a >= rt_pkg::A_RAIL) && ((off >> rt_pkg::RAIL_SH) < 12'(rt_pkg::RAILS));
    endfunction : rail_hit

    function automatic logic [4:0] rail_idx(input logic [11:0] a);
        logic [11:0] off;
        off = a - rt_pkg::A_RAIL;
        rail_idx = off[rt_pkg::RAIL_SH +: 5];
    endfunction : rail_idx

    function automatic logic [31:0] cfg_word(input logic [4:0] r);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[rt_pkg::TYPE_LSB +: 2] = type_q[r];
        w[rt_pkg::DAC_BIT] = dac_pwm_q[r];
        w[rt_pkg::DLY_LSB +: 8] = delay_q[r];
        cfg_word = w;
    endfunction : cfg_word

    function automatic logic [31:0] rail_word(input logic [4:0] r, input logic [2:0] f);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (f == rt_pkg::F_CFG) begin
            w = cfg_word(r);
        end else if (f == rt_pkg::F_LEVEL) begin
            w[11:0] = level_q[r];
        end else begin
            w[11:0] = set_q[r][3'(f - rt_pkg::F_TPIN)];
        end
        rail_word = w;
    endfunction : rail_word

    axil_slave u_bus (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rif(rif.bus)
    );

    assign wr_rail = rif.wr && rail_hit(rif.waddr);
    assign wr_idx = rail_idx(rif.waddr);
    assign wr_fld = rif.waddr[4:2];
    assign reload = rif.wr && rif.waddr == rt_pkg::A_CTRL && rif.wstrb[0]
        && rif.wdata[rt_pkg::RELOAD_BIT];
    assign rif.werr = !(rail_hit(rif.waddr) || rif.waddr == rt_pkg::A_CTRL
        || rif.waddr == rt_pkg::A_STATUS);

    // A process rather than a continuous assignment, so that a change of the
    // stored word is seen as well as a change of the bus inputs
    always_comb begin
        wr_word = rt_pkg::merge(rail_word(wr_idx, wr_fld), rif.wdata, rif.wstrb);
    end

    always_comb begin
        rif.rdata = 32'h0000_0000;
        rif.rerr = 1'b0;
        if (rif.raddr == rt_pkg::A_STATUS) begin
            rif.rdata[rt_pkg::ST_UP_BIT] = all_up;
            rif.rdata[rt_pkg::ST_ACT_BIT] = trim_active;
        end else if (rail_hit(rif.raddr)) begin
            rif.rdata = rail_word(rail_idx(rif.raddr), rif.raddr[4:2]);
        end else if (rif.raddr != rt_pkg::A_CTRL) begin
            rif.rerr = 1'b1;
        end
    end

    // Settings storage; the level word of a rail block is read-only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int r = 0; r < rt_pkg::RAILS; r++) begin
                type_q[r] <= rt_pkg::TY_NONE;
                dac_pwm_q[r] <= rt_pkg::DAC_PWM;
                delay_q[r] <= 8'h00;
                for (int s = 0; s < rt_pkg::NSET; s++) begin
                    set_q[r][s] <= rt_pkg::ZERO_MV;
                end
            end
        end else if (wr_rail && wr_fld == rt_pkg::F_CFG) begin
            type_q[wr_idx] <= wr_word[rt_pkg::TYPE_LSB +: 2];
            dac_pwm_q[wr_idx] <= wr_word[rt_pkg::DAC_BIT];
            // Kept for software only; nothing in the engine waits on it
            delay_q[wr_idx] <= wr_word[rt_pkg::DLY_LSB +: 8];
        end else if (wr_rail && wr_fld >= rt_pkg::F_TPIN && wr_fld <= rt_pkg::F_MLO) begin
            set_q[wr_idx][3'(wr_fld - rt_pkg::F_TPIN)] <= wr_word[11:0];
        end
    end

    assign meas = rail_mv[scan_q*rt_pkg::MV_W +: rt_pkg::MV_W];
    assign cur_lvl = level_q[scan_q];
    assign tgt = rt_pkg::pick(set_q[scan_q][rt_pkg::S_NOM], set_q[scan_q][rt_pkg::S_MHI],
        set_q[scan_q][rt_pkg::S_MLO]);
    assign trim_go = state_q == rt_pkg::ST_TRIM && type_q[scan_q] == rt_pkg::TY_CLOSED;

    // Trim engine: one rail is visited per cycle, so a full pass is 22 cycles
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= rt_pkg::ST_LOAD;
            scan_q <= 5'h00;
            trim_active <= 1'b0;
            for (int r = 0; r < rt_pkg::RAILS; r++) begin
                level_q[r] <= rt_pkg::ZERO_MV;
            end
        end else begin
            case (state_q)
                rt_pkg::ST_LOAD: begin
                    for (int r = 0; r < rt_pkg::RAILS; r++) begin
                        if (type_q[r] == rt_pkg::TY_NONE) begin
                            level_q[r] <= rt_pkg::ZERO_MV;
                        end else begin
                            level_q[r] <= rt_pkg::clamp(rt_pkg::pick(set_q[r][rt_pkg::S_TPIN],
                                set_q[r][rt_pkg::S_THI], set_q[r][rt_pkg::S_TLO]));
                        end
                    end
                    scan_q <= 5'h00;
                    trim_active <= 1'b0;
                    state_q <= rt_pkg::ST_HOLD;
                end
                rt_pkg::ST_HOLD: begin
                    if (all_up) begin
                        trim_active <= 1'b1;
                        state_q <= rt_pkg::ST_TRIM;
                    end
                end
                rt_pkg::ST_TRIM: begin
                    scan_q <= (scan_q == rt_pkg::LAST_RAIL) ? 5'h00 : 5'(scan_q + 5'h01);
                    // Open-loop and unused rails are skipped, their level never moves
                    if (trim_go) begin
                        if (meas > tgt && cur_lvl < rt_pkg::FULL_MV) begin
                            level_q[scan_q] <= 12'(cur_lvl + rt_pkg::ONE_MV);
                        end else if (meas < tgt && cur_lvl > rt_pkg::ZERO_MV) begin
                            level_q[scan_q] <= 12'(cur_lvl - rt_pkg::ONE_MV);
                        end
                    end
                end
                default: begin
                    state_q <= rt_pkg::ST_LOAD;
                end
            endcase
            // Acts as the reset that reapplies start levels after reprogramming
            if (reload) begin
                state_q <= rt_pkg::ST_LOAD;
                trim_active <= 1'b0;
            end
        end
    end

    // Sigma-delta selection or type none leaves the pin low
    for (genvar g = 0; g < rt_pkg::RAILS; g++) begin : g_dac
        assign rail_on[g] = type_q[g] != rt_pkg::TY_NONE && dac_pwm_q[g] == rt_pkg::DAC_PWM;
        pdm_dac u_dac (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .en(rail_on[g]),
            .level(level_q[g]),
            .out(pwm_out[g])
        );
    end

    logic [11:0] lvl0;
    logic [11:0] load0;
    assign lvl0 = level_q[0];
    assign load0 = rt_pkg::clamp(rt_pkg::pick(set_q[0][rt_pkg::S_TPIN], set_q[0][rt_pkg::S_THI],
        set_q[0][rt_pkg::S_TLO]));

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_go;
        state_q == rt_pkg::ST_HOLD && all_up && !reload;
    endsequence
    sequence s_trimming;
        state_q == rt_pkg::ST_TRIM && trim_active;
    endsequence

    chk_none_no_drive: assert property ((pwm_out & ~$past(rail_on)) == '0)
        else $error("rail without trim drove its pin");
    chk_sd_no_drive: assert property ((pwm_out & ~$past(dac_pwm_q)) == '0)
        else $error("sigma-delta selected rail drove its pin");
    chk_load_priority: assert property (state_q == rt_pkg::ST_LOAD && !reload
        && type_q[0] != rt_pkg::TY_NONE |=> lvl0 == $past(load0))
        else $error("start level not taken in priority order");
    chk_open_hold: assert property (state_q != rt_pkg::ST_LOAD
        && type_q[0] == rt_pkg::TY_OPEN |=> $stable(lvl0))
        else $error("open-loop level moved");
    chk_wait_up: assert property (state_q == rt_pkg::ST_HOLD |=> $stable(lvl0))
        else $error("level moved before rails were up");
    chk_go_trim: assert property (s_go |=> s_trimming)
        else $error("trimming did not start after all rails up");
    chk_step_up: assert property (trim_go && meas > tgt && cur_lvl < rt_pkg::FULL_MV
        |=> level_q[$past(scan_q)] == 12'($past(cur_lvl) + rt_pkg::ONE_MV))
        else $error("rail above target did not step up by one");
    chk_step_down: assert property (trim_go && meas < tgt && cur_lvl > rt_pkg::ZERO_MV
        |=> level_q[$past(scan_q)] == 12'($past(cur_lvl) - rt_pkg::ONE_MV))
        else $error("rail below target did not step down by one");
    chk_step_hold: assert property (trim_go && (meas == tgt || (meas > tgt
        && cur_lvl == rt_pkg::FULL_MV)) |=> level_q[$past(scan_q)] == $past(cur_lvl))
        else $error("level moved at target or past full scale");
    chk_scan_wrap: assert property (s_trimming ##0 scan_q == rt_pkg::LAST_RAIL && !reload
        |=> scan_q == 5'h00)
        else $error("scan did not wrap after last rail");
endmodule : rail_trim_controller

// *** rt_pkg.sv ***
package rt_pkg;
    localparam int RAILS = 22;
    localparam int MV_W = 12;
    localparam int NSET = 6;
    localparam logic [4:0] LAST_RAIL = 5'h15;
    // Trim codes are millivolts at the DAC output, 0 to 3300
    localparam logic [11:0] FULL_MV = 12'hCE4;
    localparam logic [11:0] ZERO_MV = 12'h000;
    localparam logic [11:0] ONE_MV = 12'h001;
    // Trim type field encodings
    localparam logic [1:0] TY_NONE = 2'h0;
    localparam logic [1:0] TY_OPEN = 2'h1;
    localparam logic [1:0] TY_CLOSED = 2'h2;
    // Config word layout
    localparam int TYPE_LSB = 0;
    localparam int DAC_BIT = 2;
    localparam int DLY_LSB = 8;
    localparam logic DAC_PWM = 1'h1;
    // Register map
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_RAIL = 12'h100;
    localparam int RAIL_SH = 5;
    localparam int RELOAD_BIT = 0;
    localparam int ST_UP_BIT = 0;
    localparam int ST_ACT_BIT = 1;
    // Field index within a rail block, word addressed
    localparam logic [2:0] F_CFG = 3'h0;
    localparam logic [2:0] F_TPIN = 3'h1;
    localparam logic [2:0] F_MLO = 3'h6;
    localparam logic [2:0] F_LEVEL = 3'h7;
    localparam int S_TPIN = 0;
    localparam int S_THI = 1;
    localparam int S_TLO = 2;
    localparam int S_NOM = 3;
    localparam int S_MHI = 4;
    localparam int S_MLO = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {ST_LOAD, ST_HOLD, ST_TRIM} eng_state_t;

    // First non-zero of three settings; zero means unset
    function automatic logic [11:0] pick(input logic [11:0] a, input logic [11:0] b,
                                         input logic [11:0] c);
        pick = (a != ZERO_MV) ? a : ((b != ZERO_MV) ? b : c);
    endfunction : pick

    function automatic logic [11:0] clamp(input logic [11:0] v);
        clamp = (v > FULL_MV) ? FULL_MV : v;
    endfunction : clamp

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = m;
    endfunction : merge
endpackage : rt_pkg

// *** reg_if.sv ***
`timescale 1ns/1ns
interface reg_if;
    logic wr;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic werr;
    logic [11:0] raddr;
    logic [31:0] rdata;
    logic rerr;
    modport bus (output wr, waddr, wdata, wstrb, raddr, input werr, rdata, rerr);
    modport regs (input wr, waddr, wdata, wstrb, raddr, output werr, rdata, rerr);
endinterface : reg_if

// *** pdm_dac.sv ***
`timescale 1ns/1ns
module pdm_dac (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Drive level
    input wire logic en,
    input wire logic [11:0] level,
    // Pin
    output logic out
);
    logic [11:0] acc_q;
    logic [12:0] sum;

    // First-order accumulator spreads the high cycles evenly, so the RC
    // filter sees far less ripple than a plain counter-compare PWM
    assign sum = {1'b0, acc_q} + {1'b0, level};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            acc_q <= rt_pkg::ZERO_MV;
            out <= 1'b0;
        end else if (!en) begin
            acc_q <= rt_pkg::ZERO_MV;
            out <= 1'b0;
        end else if (sum >= {1'b0, rt_pkg::FULL_MV}) begin
            acc_q <= 12'(sum - {1'b0, rt_pkg::FULL_MV});
            out <= 1'b1;
        end else begin
            acc_q <= sum[11:0];
            out <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_full_scale_high: assert property (en && level == rt_pkg::FULL_MV |=> out)
        else $error("full-scale code did not drive high");
    chk_zero_code_low: assert property (!en || level == rt_pkg::ZERO_MV |=> !out)
        else $error("zero code or disabled drove high");
endmodule : pdm_dac

// *** axil_slave.sv ***
`timescale 1ns/1ns
module axil_slave (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Write channels
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    reg_if.bus rif
);
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Address and data are held until both are in, then written once
    assign rif.wr = !awready && !wready && !bvalid;
    assign rif.waddr = awaddr_q;
    assign rif.wdata = wdata_q;
    assign rif.wstrb = wstrb_q;
    assign rif.raddr = araddr;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= rt_pkg::RESP_OKAY;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awaddr_q <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                wready <= 1'b0;
            end
            if (rif.wr) begin
                bvalid <= 1'b1;
                bresp <= rif.werr ? rt_pkg::RESP_SLVERR : rt_pkg::RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= rt_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rif.rdata;
            rresp <= rif.rerr ? rt_pkg::RESP_SLVERR : rt_pkg::RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule : axil_slave

// *** rail_filter_model.sv ***
`timescale 1ns/1ns
module rail_filter_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Trim pins and regulator set points
    input wire logic [rt_pkg::RAILS-1:0] pwm_out,
    input wire logic [rt_pkg::RAILS*rt_pkg::MV_W-1:0] vset_mv,
    // Regulator outputs and filtered trim voltages
    output logic [rt_pkg::RAILS*rt_pkg::MV_W-1:0] rail_mv,
    output logic [rt_pkg::RAILS*rt_pkg::MV_W-1:0] filt_mv
);
    // First-order low-pass, time constant 64 cycles, so ripple of a dense pulse train stays small
    logic [17:0] acc_q [rt_pkg::RAILS];
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int r = 0; r < rt_pkg::RAILS; r++) begin
                acc_q[r] <= 18'h00000;
            end
        end else begin
            for (int r = 0; r < rt_pkg::RAILS; r++) begin
                acc_q[r] <= acc_q[r] - (acc_q[r] >> 6) + (pwm_out[r] ? 18'(rt_pkg::FULL_MV) : 18'h00000);
            end
        end
    end
    always_comb begin
        for (int r = 0; r < rt_pkg::RAILS; r++) begin
            filt_mv[r*rt_pkg::MV_W +: rt_pkg::MV_W] = acc_q[r][17:6];
        end
    end
    // Regulator output is set by the bench; trim sensitivity is not modelled
    assign rail_mv = vset_mv;
endmodule : rail_filter_model

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic clk_sys, nrst, awvalid, wvalid, bready, arvalid, rready, all_up;
    logic awready, wready, bvalid, arready, rvalid, trim_active;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [rt_pkg::RAILS*rt_pkg::MV_W-1:0] vset_mv, rail_mv, filt_mv;
    logic [rt_pkg::RAILS-1:0] pwm_out;
    int error_cnt, checked, cyc, n21, n1, nz, f1sum;

    rail_trim_controller rail_trim_controller_i (.clk_sys(clk_sys), .nrst(nrst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rail_mv(rail_mv), .all_up(all_up),
        .pwm_out(pwm_out), .trim_active(trim_active));
    rail_filter_model rail_filter_model_i (.clk_sys(clk_sys), .nrst(nrst), .pwm_out(pwm_out),
        .vset_mv(vset_mv), .rail_mv(rail_mv), .filt_mv(filt_mv));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Generous ceiling: the whole sequence needs about 4000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, got);
        end
    endtask : chk_rng

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        chk("bresp", 32'(er), 32'(bresp));
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        d = rdata;
        chk("rresp", 32'(er), 32'(rresp));
    endtask : rd

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, rt_pkg::RESP_OKAY, d);
        chk(nm, exp, d);
    endtask : rchk

    task automatic rrng(input string nm, input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] d;
        rd(a, rt_pkg::RESP_OKAY, d);
        chk_rng(nm, lo, hi, d);
    endtask : rrng

    function automatic logic [11:0] ra(input int r, input logic [2:0] f);
        ra = rt_pkg::A_RAIL + 12'(r << rt_pkg::RAIL_SH) + 12'({f, 2'h0});
    endfunction : ra

    // Settings in field order: trim pin, trim high, trim low, nominal, margin high, margin low
    task automatic cfg_rail(input int r, input logic [31:0] cfg, input logic [11:0] v [6], input logic [11:0] mv);
        wr(ra(r, rt_pkg::F_CFG), cfg, rt_pkg::RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            wr(ra(r, 3'(i + 1)), 32'(v[i]), rt_pkg::RESP_OKAY);
        end
        vset_mv[r*rt_pkg::MV_W +: rt_pkg::MV_W] <= mv;
    endtask : cfg_rail

    initial begin
        logic [31:0] d;
        nrst = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, all_up} = 6'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'h0;
        vset_mv = '0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rchk("status", rt_pkg::A_STATUS, 32'h0);
        rchk("cfg0", ra(0, rt_pkg::F_CFG), 32'h4);
        wr(12'h800, 32'h1, rt_pkg::RESP_SLVERR);
        rd(12'h800, rt_pkg::RESP_SLVERR, d);
        chk("unmapped", 32'h0, d);
        cfg_rail(0, 32'h5, '{12'h000, 12'h352, 12'h2EE, 12'h000, 12'h000, 12'h000}, 12'h7D0);
        cfg_rail(1, 32'h5, '{12'h320, 12'h352, 12'h2EE, 12'h000, 12'h000, 12'h000}, 12'h7D0);
        cfg_rail(2, 32'hFF06, '{12'h000, 12'h000, 12'h2EE, 12'h000, 12'h000, 12'h2BC}, 12'h2C6);
        cfg_rail(3, 32'h4, '{12'h384, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000}, 12'h000);
        cfg_rail(4, 32'h1, '{12'h3E8, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000}, 12'h000);
        cfg_rail(5, 32'h6, '{12'h000, 12'h000, 12'h000, 12'h1F4, 12'h000, 12'h000}, 12'h190);
        cfg_rail(6, 32'h6, '{12'h4B0, 12'h000, 12'h000, 12'h3E8, 12'h000, 12'h000}, 12'h3E8);
        cfg_rail(7, 32'h6, '{12'h4B0, 12'h000, 12'h000, 12'h000, 12'h44C, 12'h3E8}, 12'h41A);
        cfg_rail(21, 32'h6, '{12'hFFF, 12'h000, 12'h000, 12'h064, 12'h000, 12'h000}, 12'h0C8);
        wr(rt_pkg::A_CTRL, 32'h1, rt_pkg::RESP_OKAY);
        repeat (5) @(posedge clk_sys);
        rchk("lvl0", ra(0, rt_pkg::F_LEVEL), 32'h352);
        rchk("lvl1", ra(1, rt_pkg::F_LEVEL), 32'h320);
        rchk("lvl3", ra(3, rt_pkg::F_LEVEL), 32'h0);
        rchk("lvl21", ra(21, rt_pkg::F_LEVEL), 32'(rt_pkg::FULL_MV));
        wr(ra(0, rt_pkg::F_LEVEL), 32'h123, rt_pkg::RESP_OKAY);
        rchk("lvl0 ro", ra(0, rt_pkg::F_LEVEL), 32'h352);
        repeat (100) @(posedge clk_sys);
        rchk("lvl2 hold", ra(2, rt_pkg::F_LEVEL), 32'h2EE);
        rchk("status hold", rt_pkg::A_STATUS, 32'h0);
        all_up <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("trim_active", 32'h1, 32'(trim_active));
        // One window of full code scale: duty count equals level
        repeat (3300) begin
            @(posedge clk_sys);
            if (pwm_out[21] === 1'b1) n21++;
            if (pwm_out[1] === 1'b1) n1++;
            if (pwm_out[3] !== 1'b0 || pwm_out[4] !== 1'b0) nz++;
            // Ripple at a partial duty spans some 50 mV, so rail 1 is judged on its mean
            f1sum += filt_mv[1*12 +: 12];
        end
        chk("duty21", 32'hCE4, 32'(n21));
        chk_rng("duty1", 32'h31F, 32'h321, 32'(n1));
        chk("idle pins", 32'h0, 32'(nz));
        chk_rng("filt21", 32'hCDA, 32'hCE4, 32'(filt_mv[21*12 +: 12]));
        chk_rng("filt1", 32'h302, 32'h33E, 32'(f1sum / 3300));
        rrng("lvl2 up", ra(2, rt_pkg::F_LEVEL), 32'h380, 32'h388);
        rchk("lvl5 floor", ra(5, rt_pkg::F_LEVEL), 32'h0);
        rchk("lvl6 equal", ra(6, rt_pkg::F_LEVEL), 32'h4B0);
        rrng("lvl7 down", ra(7, rt_pkg::F_LEVEL), 32'h415, 32'h41D);
        rchk("lvl21 ceil", ra(21, rt_pkg::F_LEVEL), 32'(rt_pkg::FULL_MV));
        rchk("lvl0 fixed", ra(0, rt_pkg::F_LEVEL), 32'h352);
        rchk("lvl4", ra(4, rt_pkg::F_LEVEL), 32'h3E8);
        rchk("status trim", rt_pkg::A_STATUS, 32'h3);
        all_up <= 1'b0;
        wr(rt_pkg::A_CTRL, 32'h1, rt_pkg::RESP_OKAY);
        repeat (5) @(posedge clk_sys);
        chk("trim_active off", 32'h0, 32'(trim_active));
        rchk("lvl2 reload", ra(2, rt_pkg::F_LEVEL), 32'h2EE);
        final_report();
    end
endmodule : tb_top
